// ### dr_pkg.sv
// constants, types and register map for the disturbance recorder control
// assumes one 100 MHz clock and a simple strobe-based register port
package dr_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_CMD    = 8'h04;
  localparam logic [7:0] A_CLRIDX = 8'h08;
  localparam logic [7:0] A_TRGSEL = 8'h0C;
  localparam logic [7:0] A_PRE    = 8'h10;
  localparam logic [7:0] A_LEN    = 8'h14;
  localparam logic [7:0] A_CHANS  = 8'h18;
  localparam logic [7:0] A_STATUS = 8'h1C;
  localparam logic [7:0] A_CAP    = 8'h20;
  localparam logic [7:0] A_MAXLEN = 8'h24;
  localparam logic [7:0] A_MAXPRE = 8'h28;
  localparam logic [7:0] A_BIN    = 8'h2C;
  localparam logic [7:0] A_RECSEL = 8'h30;
  localparam logic [7:0] A_RECID  = 8'h34;

  // command bit positions and reset values
  localparam int unsigned CMD_TRIG = 0;
  localparam int unsigned CMD_ALL  = 1;
  localparam int unsigned CMD_NEW  = 2;
  localparam int unsigned CMD_OLD  = 3;
  localparam logic [31:0] PRE_RST  = 32'h0000_00C8;  // 200 ms
  localparam logic [31:0] LEN_RST  = 32'h0000_03E8;  // 1000 ms

  // ----------------------------------------------------------------
  // limits and timing
  // ----------------------------------------------------------------
  localparam logic [6:0]  MAX_RECS     = 7'h64;          // 100 recordings
  localparam logic [31:0] LEN_LIMIT_MS = 32'h001B_7740;  // 1800.000 s
  localparam int unsigned NOM_HZ       = 50;
  localparam int unsigned DIG_RATE_5MS = 200;            // samples per second
  localparam int unsigned DIG_RATE_1MS = 1000;
  localparam int unsigned CLK_NS       = 10;
  localparam int unsigned MS_NS        = 1000000;
  localparam int unsigned CYC_PER_MS   = MS_NS / CLK_NS;
  localparam logic [3:0]  STORE_CYC    = 4'h8;
  localparam logic [47:0] MEM_SMS_DEF  = 48'h0007_7359_4000; // sample-ms units

  // rate field: 0=64, 1=32, 2=16, 3=8 samples per cycle
  typedef struct packed {
    logic       dig_1ms;
    logic [1:0] rate;
    logic       retain;
    logic       enable;
  } ctrl_t;
  localparam ctrl_t CTRL_RST = '{dig_1ms: 1'b0, rate: 2'h0, retain: 1'b0, enable: 1'b1};

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_TRIGD = 2'b01, ST_RECORD = 2'b11, ST_STORE = 2'b10
  } state_t;

  typedef enum logic [2:0] {
    S_READY = 3'h0, S_TRIGGERED = 3'h1, S_REC_STORE = 3'h2,
    S_STORING = 3'h3, S_FULL = 3'h4, S_WRONG = 3'h5
  } status_t;

endpackage

// ### disturbance_recorder_control.sv
// disturbance recorder control: triggering, recording store, status
// assumes software on the same clock and binary channels from pins
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/10ps
module disturbance_recorder_control #(
  parameter int unsigned NDIN       = 16,
  parameter int unsigned CYC_PER_MS = dr_pkg::CYC_PER_MS,
  parameter logic [47:0] MEM_SMS    = dr_pkg::MEM_SMS_DEF
) (
  input  wire logic             mclk,
  input  wire logic             rstn,
  input  wire dr_pkg::bus_req_t bus,
  output logic [31:0]           rdata,
  input  wire logic [NDIN-1:0]  din,
  input  wire logic             phase_sequence_reversed,
  input  wire logic             internal_fault,
  input  wire logic             time_sync_lost_flag,
  output dr_pkg::status_t       status,
  output logic [6:0]            rec_count,
  output logic                  recording
);
  import dr_pkg::*;

  localparam int unsigned NSRC = NDIN + 5;

  // ----------------------------------------------------------------
  // pin synchronisers and binary channel vector
  // ----------------------------------------------------------------
  logic [NDIN+2:0] pin_m_q;
  logic [NDIN+2:0] pin_s_q;
  logic [NSRC-1:0] src;
  logic [NSRC-1:0] src_q;

  // two flops per pin; only the second stage feeds logic
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_m_q <= '0;
      pin_s_q <= '0;
    end else begin
      pin_m_q <= {time_sync_lost_flag, internal_fault, phase_sequence_reversed, din};
      pin_s_q <= pin_m_q;
    end
  end

  // internal fault channel, sync alarm channel
  assign src = {pin_s_q[NDIN+2:NDIN], 1'b1, 1'b0, pin_s_q[NDIN-1:0]};

  // reset to the idle levels, constant-one channel included, so no false edge follows reset
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) src_q <= {3'b000, 1'b1, 1'b0, {NDIN{1'b0}}};
    else       src_q <= src;
  end

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  ctrl_t           ctrl_q;
  logic [NSRC-1:0] sel_q;
  logic [31:0]     pre_q;
  logic [31:0]     len_q;
  logic [4:0]      ach_q;
  logic [5:0]      dch_q;
  logic [6:0]      recsel_q;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q   <= CTRL_RST;
      sel_q    <= '0;
      pre_q    <= PRE_RST;
      len_q    <= LEN_RST;
      ach_q    <= '0;
      dch_q    <= '0;
      recsel_q <= '0;
    end else if (bus.wr) begin
      unique case (bus.addr)
        A_CTRL:   ctrl_q   <= ctrl_t'(bus.wdata[4:0]);
        A_TRGSEL: sel_q    <= bus.wdata[NSRC-1:0];
        A_PRE:    pre_q    <= bus.wdata;
        A_LEN:    len_q    <= bus.wdata;
        A_CHANS: begin
          ach_q <= bus.wdata[4:0];
          dch_q <= bus.wdata[13:8];
        end
        A_RECSEL: recsel_q <= bus.wdata[6:0];
        default: ;
      endcase
    end
  end

  // command strokes are pulses; the command register reads back idle
  logic cmd_wr;
  logic idx_wr;
  logic man_trig;
  logic cmd_all;
  logic cmd_new;
  logic cmd_old;
  logic cmd_any;
  assign cmd_wr   = bus.wr && (bus.addr == A_CMD);
  assign idx_wr   = bus.wr && (bus.addr == A_CLRIDX);
  assign man_trig = cmd_wr && bus.wdata[CMD_TRIG];
  assign cmd_all  = cmd_wr && bus.wdata[CMD_ALL];
  assign cmd_new  = cmd_wr && bus.wdata[CMD_NEW];
  assign cmd_old  = cmd_wr && bus.wdata[CMD_OLD];
  assign cmd_any  = cmd_all || cmd_new || cmd_old || idx_wr;

  // ----------------------------------------------------------------
  // capacity calculation
  // ----------------------------------------------------------------
  logic [31:0] spc;
  logic [31:0] rate_u;
  logic [47:0] size_u;
  // data rate from channels and sample rates
  assign spc    = 32'd64 >> ctrl_q.rate;
  assign rate_u = 32'(ach_q) * spc * NOM_HZ
                + 32'(dch_q) * (ctrl_q.dig_1ms ? DIG_RATE_1MS : DIG_RATE_5MS);
  assign size_u = 48'(rate_u) * 48'(len_q);

  // one shared restoring divider alternates between length and count
  logic [47:0] rem_q;
  logic [47:0] quo_q;
  logic [47:0] dvs_q;
  logic [5:0]  it_q;
  logic        ph_q;
  logic        done_q;
  logic [31:0] maxlen_q;
  logic [6:0]  cap_q;
  logic [47:0] rs;
  assign rs = {rem_q[46:0], quo_q[47]};

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rem_q    <= '0;
      quo_q    <= '0;
      dvs_q    <= '0;
      it_q     <= '0;
      ph_q     <= 1'b0;
      done_q   <= 1'b0;
      maxlen_q <= '0;
      cap_q    <= '0;
    end else if (it_q == 6'd0) begin
      if (done_q) begin
        // length clamped at the upper limit
        if (!ph_q) maxlen_q <= (quo_q > 48'(LEN_LIMIT_MS)) ? LEN_LIMIT_MS : quo_q[31:0];
        else       cap_q <= (quo_q > 48'(MAX_RECS)) ? MAX_RECS : quo_q[6:0];
        ph_q <= !ph_q;
      end
      rem_q  <= '0;
      quo_q  <= MEM_SMS;
      dvs_q  <= done_q ? (ph_q ? 48'(rate_u) : size_u) : (ph_q ? size_u : 48'(rate_u));
      it_q   <= 6'd48;
      done_q <= 1'b0;
    end else begin
      if (rs >= dvs_q) begin
        rem_q <= rs - dvs_q;
        quo_q <= {quo_q[46:0], 1'b1};
      end else begin
        rem_q <= rs;
        quo_q <= {quo_q[46:0], 1'b0};
      end
      it_q   <= it_q - 6'd1;
      done_q <= (it_q == 6'd1);
    end
  end

  // ----------------------------------------------------------------
  // configuration check and trigger qualification
  // ----------------------------------------------------------------
  logic        bad_pre;
  logic        bad_ovw;
  logic        bad_rate;
  logic        wrong;
  logic        full;
  logic        src_hit;
  logic        start_ok;
  logic [31:0] maxpre;
  state_t      state_q;
  logic [6:0]  count_q;

  assign bad_pre  = pre_q > maxlen_q;
  assign bad_ovw  = (cap_q == 7'd1) && !ctrl_q.retain;
  // fast digital sampling needs 32 or 64 s/c
  assign bad_rate = ctrl_q.dig_1ms && ctrl_q.rate[1];
  assign wrong    = bad_pre || bad_ovw || bad_rate;
  assign full     = count_q >= cap_q;
  assign maxpre   = (len_q < maxlen_q) ? len_q : maxlen_q;

  assign src_hit  = |(sel_q & src & ~src_q);
  // manual or automatic start, enable gates it
  // refused when wrong or full in retain mode
  assign start_ok = ctrl_q.enable && !wrong && (man_trig || src_hit)
                 && !(full && (ctrl_q.retain || cap_q == 7'd0));

  // ----------------------------------------------------------------
  // recording sequence
  // ----------------------------------------------------------------
  logic [31:0] ms_cnt_q;
  logic        ms_tick;
  logic [31:0] post_q;
  logic [3:0]  stc_q;
  logic        sh_busy_q;
  logic        commit;
  logic        ovw;
  logic        drop;

  // free-running millisecond tick
  assign ms_tick = (ms_cnt_q == 32'(CYC_PER_MS - 1));
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn)        ms_cnt_q <= '0;
    else if (ms_tick) ms_cnt_q <= '0;
    else              ms_cnt_q <= ms_cnt_q + 32'd1;
  end

  // clears take the slot first; storage waits until they and any compaction finish
  assign commit = (state_q == ST_STORE) && (stc_q == 4'd0) && !sh_busy_q
               && !cmd_any && (count_q < cap_q);
  // overwrite mode evicts oldest when full
  assign ovw    = (state_q == ST_STORE) && (stc_q == 4'd0) && !sh_busy_q
               && !cmd_any && full && !ctrl_q.retain && (count_q != 7'd0);
  assign drop   = (state_q == ST_STORE) && (stc_q == 4'd0) && !sh_busy_q
               && !cmd_any && full && (ctrl_q.retain || count_q == 7'd0);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      post_q  <= '0;
      stc_q   <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: if (start_ok) state_q <= ST_TRIGD;
        ST_TRIGD: begin
          // pretrigger part already captured, record the rest
          post_q  <= (len_q > pre_q) ? len_q - pre_q : 32'd0;
          state_q <= ST_RECORD;
        end
        ST_RECORD: begin
          if (post_q == 32'd0) begin
            stc_q   <= STORE_CYC;
            state_q <= ST_STORE;
          end else if (ms_tick) begin
            post_q <= post_q - 32'd1;
          end
        end
        ST_STORE: begin
          if (stc_q != 4'd0) stc_q <= stc_q - 4'd1;
          else if (commit || drop) state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // recording store, oldest first
  // ----------------------------------------------------------------
  logic [15:0] mem [MAX_RECS];
  logic [15:0] ser_q;
  logic [6:0]  sh_pos_q;
  logic        sh_fin;
  logic        del_start;
  logic [6:0]  del_idx;
  logic        new_ok;

  assign sh_fin = sh_busy_q && (sh_pos_q + 7'd1 >= count_q);

  always_comb begin
    del_start = 1'b0;
    del_idx   = '0;
    if (!sh_busy_q && !cmd_all) begin
      if (cmd_old && count_q != 7'd0) begin
        del_start = 1'b1;
      // index one names the first recording
      end else if (idx_wr && bus.wdata != 32'd0 && bus.wdata <= 32'(count_q)) begin
        del_start = 1'b1;
        del_idx   = bus.wdata[6:0] - 7'd1;
      end else if (ovw) begin
        del_start = 1'b1;
      end
    end
  end
  // newest is the top slot, drop it directly
  assign new_ok = cmd_new && !sh_busy_q && !cmd_all && !del_start && (count_q != 7'd0);

  // deletion compacts the store one slot per cycle
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sh_busy_q <= 1'b0;
      sh_pos_q  <= '0;
    end else if (cmd_all || sh_fin) begin
      sh_busy_q <= 1'b0;
    end else if (sh_busy_q) begin
      sh_pos_q <= sh_pos_q + 7'd1;
    end else if (del_start) begin
      sh_busy_q <= 1'b1;
      sh_pos_q  <= del_idx;
    end
  end

  // entry contents hold a serial id; no reset needed for data
  always_ff @(posedge mclk) begin
    if (commit) mem[count_q] <= ser_q;
    else if (sh_busy_q && !sh_fin) mem[sh_pos_q] <= mem[sh_pos_q + 7'd1];
  end

  // clear all wins; append only below capacity
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
      ser_q   <= '0;
    end else begin
      if (cmd_all) count_q <= '0;
      else if (commit) count_q <= count_q + 7'd1;
      else if (sh_fin || new_ok) count_q <= count_q - 7'd1;
      if (commit) ser_q <= ser_q + 16'd1;
    end
  end

  // ----------------------------------------------------------------
  // outputs and read port
  // ----------------------------------------------------------------
  status_t status_d;
  always_comb begin
    // wrong config outranks the sequence state
    if (wrong) status_d = S_WRONG;
    else begin
      unique case (state_q)
        ST_IDLE:   status_d = full ? S_FULL : S_READY;
        ST_TRIGD:  status_d = S_TRIGGERED;
        ST_RECORD: status_d = S_REC_STORE;
        ST_STORE:  status_d = S_STORING;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status    <= S_READY;
      rec_count <= '0;
      recording <= 1'b0;
    end else begin
      status    <= status_d;
      rec_count <= count_q;
      recording <= (state_q != ST_IDLE);
    end
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) rdata <= '0;
    else if (!bus.rd) rdata <= '0;
    else begin
      unique case (bus.addr)
        A_CTRL:   rdata <= 32'(ctrl_q);
        A_TRGSEL: rdata <= 32'(sel_q);
        A_PRE:    rdata <= pre_q;
        A_LEN:    rdata <= len_q;
        A_CHANS:  rdata <= {18'd0, dch_q, 3'd0, ach_q};
        A_STATUS: rdata <= {17'd0, count_q, 5'd0, status_d};
        A_CAP:    rdata <= 32'(cap_q);
        A_MAXLEN: rdata <= maxlen_q;
        A_MAXPRE: rdata <= maxpre;
        A_BIN:    rdata <= 32'(src);
        A_RECSEL: rdata <= 32'(recsel_q);
        A_RECID:  rdata <= (recsel_q < count_q) ? 32'(mem[recsel_q]) : 32'd0;
        default:  rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence s_man_start;
    state_q == ST_IDLE && man_trig && start_ok;
  endsequence
  sequence s_run;
    state_q == ST_TRIGD ##1 state_q == ST_RECORD;
  endsequence

  manual_start_a: assert property (s_man_start |=> s_run)
    else $error("manual trigger did not start a recording");
  enable_gate_a: assert property (!ctrl_q.enable |=> state_q != ST_TRIGD)
    else $error("recording started while disabled");
  busy_ignore_a: assert property (state_q != ST_IDLE |=> state_q != ST_TRIGD)
    else $error("trigger accepted during a recording");
  pre_check_a: assert property (bad_pre |=> status == S_WRONG)
    else $error("pretrigger overrun not flagged");
  ovw_check_a: assert property (cap_q == 7'd1 && !ctrl_q.retain |=> status == S_WRONG)
    else $error("single slot overwrite not flagged");
  rate_check_a: assert property (ctrl_q.dig_1ms && ctrl_q.rate >= 2'd2
                                 |=> status == S_WRONG)
    else $error("1 ms with 8 or 16 s/c not flagged");
  count_cap_a: assert property (count_q <= MAX_RECS && cap_q <= MAX_RECS)
    else $error("store holds more than 100");
  clear_all_a: assert property (cmd_all |=> count_q == 7'd0 ##1 rec_count == 7'd0)
    else $error("clear all left recordings");
  clear_new_a: assert property (new_ok |=> count_q == $past(count_q) - 7'd1)
    else $error("clear newest did not drop one");
  retain_full_a: assert property (state_q == ST_IDLE && full && ctrl_q.retain
                                  |=> state_q == ST_IDLE)
    else $error("retain mode accepted while full");

endmodule

// ### disturbance_recorder_control_bench.sv
// self-checking bench for the disturbance recorder control block
// assumes dr_pkg is compiled first; the bench alone drives every block input
`timescale 1ns/10ps
module disturbance_recorder_control_bench;
  import dr_pkg::*;
  localparam int unsigned NDIN = 16;
  localparam int unsigned NSRC = NDIN + 5;

  logic            mclk;
  logic            rstn;
  bus_req_t        bus;
  logic [31:0]     rdata;
  logic [NSRC-1:0] src;
  status_t         status;
  logic [6:0]      rec_count;
  logic            recording;
  logic [31:0]     expq[$];
  logic [31:0]     seed;
  logic            pend;
  int              error_cnt;
  int              compares;
  int              ks[4];

  // ----------------------------------------------------------------
  // clock and block under test
  // ----------------------------------------------------------------
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // tiny memory and 10-cycle millisecond keep recordings short and capacity at three
  disturbance_recorder_control #(
    .NDIN       (NDIN),
    .CYC_PER_MS (10),
    .MEM_SMS    (48'h0000_0000_bb80)
  ) disturbance_recorder_control_inst (
    .mclk                    (mclk),
    .rstn                    (rstn),
    .bus                     (bus),
    .rdata                   (rdata),
    .din                     (src[NDIN-1:0]),
    .phase_sequence_reversed (src[NDIN+2]),
    .internal_fault          (src[NDIN+3]),
    .time_sync_lost_flag     (src[NDIN+4]),
    .status                  (status),
    .rec_count               (rec_count),
    .recording               (recording)
  );

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] sw(input logic [6:0] c, input status_t s);
    return {17'h0_0000, c, 5'h00, s};
  endfunction

  task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t read data %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_port(input logic [7:0] got, input logic [7:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s %h expected %h", $time, m, got, exp);
    end
  endtask

  // read data stand only in the cycle after the strobe, so look mid-cycle there
  always @(posedge mclk) pend <= bus.rd;
  always @(negedge mclk) begin
    if (pend === 1'b1) begin
      if (expq.size() == 0) begin
        error_cnt++;
        $display("MISMATCH %0t read without a note", $time);
      end else begin
        cmp_rd(rdata, expq.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // register port and trigger tasks
  // ----------------------------------------------------------------
  // an idle cycle after each strobe keeps one assignment per time step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus <= '0;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus <= '0;
    @(posedge mclk);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wait_rec(input logic v, input int n);
    int i;
    for (i = 0; i < n; i++) begin
      @(negedge mclk);
      if (recording === v) break;
    end
    cmp_port({7'h00, recording}, {7'h00, v}, "recording");
    @(posedge mclk);
  endtask

  task automatic done();
    wait_rec(1'b1, 8);
    wait_rec(1'b0, 400);
    idle(3);
  endtask

  task automatic no_rec();
    repeat (8) @(negedge mclk);
    cmp_port({7'h00, recording}, 8'h00, "ignored trigger");
    @(posedge mclk);
  endtask

  // sample the registered count mid-cycle, away from the edge that updates it
  task automatic cnt(input logic [6:0] c);
    @(negedge mclk);
    cmp_port({1'b0, rec_count}, {1'b0, c}, "count");
    @(posedge mclk);
  endtask

  // raise one source with random unselected pins around it
  task automatic src_trig(input int k);
    logic [NSRC-1:0] r;
    logic [31:0]     x;
    x = xs();
    r = '0;
    r[NDIN-1:0] = x[NDIN-1:0];
    r[k] = 1'b0;
    wr(A_TRGSEL, 32'h0000_0001 << k);
    rd(A_TRGSEL, 32'h0000_0001 << k);
    src <= r;
    idle(4);
    src[k] <= 1'b1;
    r[k] = 1'b1;
    r[NDIN+1] = 1'b1;
    idle(4);
    rd(A_BIN, 32'(r));
    done();
    src <= '0;
    idle(4);
  endtask

  task automatic give_verdict();
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    bus = '0;
    src = '0;
    rstn = 1'b0;
    seed = 32'he8f0_5edf;
    error_cnt = 0;
    compares = 0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    cnt(7'h00);
    rd(A_CTRL, 32'h0000_0001);
    wr(A_CHANS, 32'h0000_0001);
    wr(A_LEN, 32'h0000_0005);
    wr(A_PRE, 32'h0000_0002);
    idle(200);
    rd(A_CAP, 32'h0000_0003);
    rd(A_MAXLEN, 32'h0000_000f);
    rd(A_MAXPRE, 32'h0000_0005);
    rd(A_STATUS, sw(7'h00, S_READY));
    rd(8'h3c, 32'h0000_0000);
    wr(A_CMD, 32'h0000_0001);
    done();
    rd(A_CMD, 32'h0000_0000);
    rd(A_STATUS, sw(7'h01, S_READY));
    ks[0] = int'(xs() % NDIN);
    ks[1] = NDIN + 2;
    ks[2] = NDIN + 3;
    ks[3] = NDIN + 4;
    foreach (ks[i]) src_trig(ks[i]);
    // five stored in overwrite mode with room for three: ids 2..4 remain
    cnt(7'h03);
    wr(A_RECSEL, 32'h0000_0000);
    rd(A_RECID, 32'h0000_0002);
    wr(A_CMD, 32'h0000_0004);
    idle(4);
    cnt(7'h02);
    wr(A_RECSEL, 32'h0000_0001);
    rd(A_RECID, 32'h0000_0003);
    wr(A_CMD, 32'h0000_0008);
    idle(10);
    cnt(7'h01);
    wr(A_RECSEL, 32'h0000_0000);
    rd(A_RECID, 32'h0000_0003);
    // retain mode; a second trigger inside a recording must not count
    wr(A_CTRL, 32'h0000_0003);
    wr(A_CMD, 32'h0000_0001);
    wait_rec(1'b1, 8);
    wr(A_CMD, 32'h0000_0001);
    wait_rec(1'b0, 400);
    idle(3);
    cnt(7'h02);
    wr(A_CMD, 32'h0000_0001);
    done();
    rd(A_STATUS, sw(7'h03, S_FULL));
    cmp_port({5'h00, status}, {5'h00, S_FULL}, "status");
    wr(A_CMD, 32'h0000_0001);
    no_rec();
    wr(A_CLRIDX, 32'h0000_0000);
    wr(A_CLRIDX, 32'h0000_0004);
    idle(10);
    cnt(7'h03);
    wr(A_CLRIDX, 32'h0000_0002);
    idle(10);
    cnt(7'h02);
    wr(A_RECSEL, 32'h0000_0001);
    rd(A_RECID, 32'h0000_0006);
    wr(A_CMD, 32'h0000_0002);
    idle(2);
    rd(A_STATUS, sw(7'h00, S_READY));
    wr(A_CTRL, 32'h0000_0000);
    wr(A_CMD, 32'h0000_0001);
    no_rec();
    wr(A_CTRL, 32'h0000_0001);
    wr(A_PRE, 32'h0000_0014);
    idle(200);
    rd(A_STATUS, sw(7'h00, S_WRONG));
    wr(A_CMD, 32'h0000_0001);
    no_rec();
    wr(A_PRE, 32'h0000_0002);
    // every analog rate with the fast digital period
    for (int r = 0; r < 4; r++) begin
      wr(A_CTRL, 32'h0000_0011 | (32'(r) << 2));
      idle(200);
      rd(A_STATUS, sw(7'h00, (r >= 2) ? S_WRONG : S_READY));
    end
    wr(A_CTRL, 32'h0000_0001);
    // four digital channels at 5 ms then 1 ms: 4000 and 7200 sample units per ms
    wr(A_CHANS, 32'h0000_0401);
    idle(200);
    rd(A_CHANS, 32'h0000_0401);
    rd(A_MAXLEN, 32'h0000_000c);
    rd(A_CAP, 32'h0000_0002);
    wr(A_CTRL, 32'h0000_0011);
    idle(200);
    rd(A_MAXLEN, 32'h0000_0006);
    wr(A_CTRL, 32'h0000_0001);
    wr(A_CHANS, 32'h0000_0001);
    wr(A_LEN, 32'h0000_000c);
    idle(200);
    wr(A_CAP, 32'h0000_0063);
    rd(A_CAP, 32'h0000_0001);
    rd(A_STATUS, sw(7'h00, S_WRONG));
    wr(A_CTRL, 32'h0000_0003);
    idle(4);
    rd(A_STATUS, sw(7'h00, S_READY));
    idle(4);
    give_verdict();
  end
endmodule
